// [src/lp_dac_switch_and_ref_regs.sv]
// Register bank for the low power DAC switches, DAC codes and reference power-down bits.
// Assumes AHB-Lite access through ahb_reg_slave and a single 40 MHz system clock.
`timescale 1ns/1ps

// Operation
// - Override clear: switches follow configuration mode bit
// - Override set: switches follow low five bits
// - Bit 4 closes bias to amplifier input
// - Bit 3 connects bias to filter pin
// - Bit 2 connects zero to lp TIA
// - Bit 1 connects zero to filter pin
// - Bit 0 connects zero to HS TIA
// - Six-bit code held in bits 17:12
// - Twelve-bit code held in bits 11:0
// - Bit 1 powers down 2.5 V buffer
// - Bit 0 powers down bandgap reference
// - Bit 3 closes common-mode switches
// - Write enable clear: code ignored, zero
// - Configuration bit 5 selects normal/diagnostic
// - DAC power-down opens every output switch
module lp_dac_switch_and_ref_regs
   import lp_dac_regs_pkg::*;
(
   input  wire logic                   mclk,                        // 40 MHz system clock
   input  wire logic                   reset_n,                     // Async reset, active low
   input  wire logic                   hsel,                        // AHB slave select
   input  wire logic [31:0]            haddr,                       // AHB byte address
   input  wire logic [1:0]             htrans,                      // AHB transfer type
   input  wire logic                   hwrite,                      // AHB write
   input  wire logic [2:0]             hsize,                       // AHB size, word only
   input  wire logic [31:0]            hwdata,                      // AHB write data
   input  wire logic                   hready,                      // AHB bus ready
   output logic [31:0]                 hrdata,                      // AHB read data
   output logic                        hreadyout,                   // AHB slave ready
   output logic                        hresp,                       // AHB response
   output logic                        bias_to_amp_input_close,     // Bias straight to amp
   output logic                        bias_to_filter_pin_close,    // Bias to filter pin
   output logic                        zero_to_lp_tia_input_close,  // Zero level to lp TIA
   output logic                        zero_to_filter_pin_close,    // Zero level to filter pin
   output logic                        zero_to_hs_tia_input_close,  // Zero level to HS TIA
   output logic [5:0]                  dac_code_6bit,               // Six-bit DAC code
   output logic [11:0]                 dac_code_12bit,              // Twelve-bit DAC code
   output logic                        dac_power_down,              // DAC powered down
   output logic                        ref_buffer_power_down,       // 2.5 V buffer off
   output logic                        bandgap_power_down,          // Bandgap off
   output logic                        common_mode_switch_enable    // Common-mode switches
);
   import lp_dac_regs_pkg::*;

   // ***************************************************************
   // Declarations
   // ***************************************************************
   reg_wr_t       wr_req;
   reg_rd_t       rd_req;
   logic [31:0]   rd_data;
   logic [31:0]   sw_ctrl_ff;
   logic [31:0]   dac_code_ff;
   logic [31:0]   ref_ctrl_ff;
   logic [31:0]   cm_mux_ff;
   logic [31:0]   dac_cfg_ff;
   logic [31:0]   nxt_sw_ctrl;
   logic [31:0]   nxt_dac_code;
   logic [31:0]   nxt_ref_ctrl;
   logic [31:0]   nxt_cm_mux;
   logic [31:0]   nxt_dac_cfg;
   logic [4:0]    nxt_switch;
   logic [4:0]    switch_ff;
   logic [5:0]    code6_ff;
   logic [11:0]   code12_ff;
   logic          dac_pd_ff;
   logic          ref_buf_pd_ff;
   logic          bandgap_pd_ff;
   logic          cm_en_ff;
   logic          unused_size;

   // Only whole-word transfers are issued on this bus
   assign unused_size = ^hsize;

   // ***************************************************************
   // Bus front end
   // ***************************************************************
   ahb_reg_slave u_ahb_reg_slave (
      .mclk      (mclk),
      .reset_n   (reset_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hwdata    (hwdata),
      .hready    (hready),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .wr_req    (wr_req),
      .rd_req    (rd_req),
      .rd_data   (rd_data)
   );

   // ***************************************************************
   // Switch vector function
   // ***************************************************************
   // Power-down wins over everything, then override, then mode pattern
   function automatic logic [4:0] eff_switch(input logic [31:0] cfg, input logic [31:0] sw);
      logic [4:0] vec;
      vec = 5'h00;
      if (cfg[CFG_PD_BIT])
         vec = 5'h00;
      else if (sw[SW_OVERRIDE_BIT])
         vec = sw[SW_VEC_W-1:0];
      else if (cfg[CFG_MODE_BIT])
         vec = SW_DIAG_SET;
      else
         vec = SW_NORMAL_SET;
      return vec;
   endfunction : eff_switch

   // ***************************************************************
   // Next register values
   // ***************************************************************
   // Writes land in the data phase; unmapped addresses are simply dropped
   always_comb
   begin
      nxt_sw_ctrl  = sw_ctrl_ff;
      nxt_ref_ctrl = ref_ctrl_ff;
      nxt_cm_mux   = cm_mux_ff;
      nxt_dac_cfg  = dac_cfg_ff;
      nxt_dac_code = dac_code_ff;
      if (wr_req.en && wr_req.addr == SW_CTRL_ADDR)
         nxt_sw_ctrl = wr_req.data & SW_CTRL_MASK;
      if (wr_req.en && wr_req.addr == REF_CTRL_ADDR)
         nxt_ref_ctrl = wr_req.data & REF_CTRL_MASK;
      if (wr_req.en && wr_req.addr == CM_MUX_ADDR)
         nxt_cm_mux = wr_req.data & CM_MUX_MASK;
      if (wr_req.en && wr_req.addr == DAC_CFG_ADDR)
         nxt_dac_cfg = wr_req.data & DAC_CFG_MASK;
      if (wr_req.en && wr_req.addr == DAC_CODE_ADDR)
         nxt_dac_code = wr_req.data & DAC_CODE_MASK;
      if (!nxt_dac_cfg[CFG_WREN_BIT])
         nxt_dac_code = 32'h0000_0000;
      nxt_switch = eff_switch(nxt_dac_cfg, nxt_sw_ctrl);
   end

   // ***************************************************************
   // Register storage
   // ***************************************************************
   // Switch control word
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         sw_ctrl_ff <= SW_CTRL_RST;
      else
         sw_ctrl_ff <= nxt_sw_ctrl;
   end

   // DAC code word, cleared while writes are disabled
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         dac_code_ff <= DAC_CODE_RST;
      else
         dac_code_ff <= nxt_dac_code;
   end

   // Reference power control word
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         ref_ctrl_ff <= REF_CTRL_RST;
      else
         ref_ctrl_ff <= nxt_ref_ctrl;
   end

   // Common-mode mux word; low reserved bits are kept as written
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         cm_mux_ff <= CM_MUX_RST;
      else
         cm_mux_ff <= nxt_cm_mux;
   end

   // DAC configuration word; resets with the DAC powered down
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         dac_cfg_ff <= DAC_CFG_RST;
      else
         dac_cfg_ff <= nxt_dac_cfg;
   end

   // ***************************************************************
   // Output flops
   // ***************************************************************
   // Outputs follow the next values so a write shows at the same edge it is stored
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         switch_ff <= 5'h00;
      else
         switch_ff <= nxt_switch;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         code6_ff  <= 6'h00;
         code12_ff <= 12'h000;
      end
      else
      begin
         code6_ff  <= nxt_dac_code[CODE6_LSB +: CODE6_W];
         code12_ff <= nxt_dac_code[CODE12_LSB +: CODE12_W];
      end
   end

   // Power-down and common-mode enable flags; the DAC one starts set to match its reset value
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         dac_pd_ff     <= 1'b1;
         ref_buf_pd_ff <= 1'b0;
         bandgap_pd_ff <= 1'b0;
         cm_en_ff      <= 1'b0;
      end
      else
      begin
         dac_pd_ff     <= nxt_dac_cfg[CFG_PD_BIT];
         ref_buf_pd_ff <= nxt_ref_ctrl[REF_BUF_PD_BIT];
         bandgap_pd_ff <= nxt_ref_ctrl[BANDGAP_PD_BIT];
         cm_en_ff      <= nxt_cm_mux[CM_EN_BIT];
      end
   end

   assign bias_to_amp_input_close    = switch_ff[SW_BIAS_AMP_BIT];
   assign bias_to_filter_pin_close   = switch_ff[SW_BIAS_FILT_BIT];
   assign zero_to_lp_tia_input_close = switch_ff[SW_ZERO_LP_BIT];
   assign zero_to_filter_pin_close   = switch_ff[SW_ZERO_FILT_BIT];
   assign zero_to_hs_tia_input_close = switch_ff[SW_ZERO_HS_BIT];
   assign dac_code_6bit              = code6_ff;
   assign dac_code_12bit             = code12_ff;
   assign dac_power_down             = dac_pd_ff;
   assign ref_buffer_power_down      = ref_buf_pd_ff;
   assign bandgap_power_down         = bandgap_pd_ff;
   assign common_mode_switch_enable  = cm_en_ff;

   // ***************************************************************
   // Read mux
   // ***************************************************************
   // Stored words are already masked, so bits outside each mask read as zero; the common-mode word's low reserved bits read back as written
   always_comb
   begin
      rd_data = 32'h0000_0000;
      if (rd_req.en)
      begin
         case (rd_req.addr)
            SW_CTRL_ADDR:  rd_data = sw_ctrl_ff;
            DAC_CODE_ADDR: rd_data = dac_code_ff;
            REF_CTRL_ADDR: rd_data = ref_ctrl_ff;
            CM_MUX_ADDR:   rd_data = cm_mux_ff;
            DAC_CFG_ADDR:  rd_data = dac_cfg_ff;
            default:       rd_data = 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence seq_code_write;
      wr_req.en && wr_req.addr == DAC_CODE_ADDR && dac_cfg_ff[CFG_WREN_BIT];
   endsequence

   sequence seq_ref_write;
      wr_req.en && wr_req.addr == REF_CTRL_ADDR;
   endsequence

   sequence seq_cm_write;
      wr_req.en && wr_req.addr == CM_MUX_ADDR;
   endsequence

   chk_override_direct : assert property (
      sw_ctrl_ff[SW_OVERRIDE_BIT] && !dac_cfg_ff[CFG_PD_BIT]
      |-> switch_ff == sw_ctrl_ff[4:0] && bias_to_amp_input_close == sw_ctrl_ff[4])
      else $error("override set but switches differ from switch bits");

   chk_normal_mode : assert property (
      !sw_ctrl_ff[SW_OVERRIDE_BIT] && !dac_cfg_ff[CFG_PD_BIT] && !dac_cfg_ff[CFG_MODE_BIT]
      |-> switch_ff == SW_NORMAL_SET)
      else $error("normal mode switch pattern not applied");

   chk_diag_mode : assert property (
      !sw_ctrl_ff[SW_OVERRIDE_BIT] && !dac_cfg_ff[CFG_PD_BIT] && dac_cfg_ff[CFG_MODE_BIT]
      |-> switch_ff == SW_DIAG_SET)
      else $error("diagnostic mode switch pattern not applied");

   chk_pd_opens_all : assert property (
      dac_cfg_ff[CFG_PD_BIT] |-> switch_ff == 5'h00 && dac_power_down)
      else $error("DAC powered down but a switch is closed");

   chk_code_held_zero : assert property (
      !dac_cfg_ff[CFG_WREN_BIT] |-> dac_code_ff == 32'h0000_0000 && dac_code_6bit == 6'h00)
      else $error("DAC code not zero while writes are disabled");

   chk_code_write : assert property (
      seq_code_write |=> dac_code_12bit == $past(wr_req.data[11:0])
                         && dac_code_6bit == $past(wr_req.data[17:12]))
      else $error("DAC code write not reflected on code outputs");

   chk_ref_power : assert property (
      seq_ref_write |=> ref_buffer_power_down == $past(wr_req.data[1])
                        && bandgap_power_down == $past(wr_req.data[0]))
      else $error("reference power-down bits did not follow write");

   // Holds a second cycle unless a back-to-back write to the same word replaces it
   chk_cm_switch : assert property (
      seq_cm_write |=> common_mode_switch_enable == $past(wr_req.data[CM_EN_BIT])
         ##1 (common_mode_switch_enable == $past(common_mode_switch_enable)
              || $past(wr_req.en && wr_req.addr == CM_MUX_ADDR)))
      else $error("common-mode switch enable did not follow write");

   chk_reserved_zero : assert property (
      rd_req.en && rd_req.addr == SW_CTRL_ADDR |-> rd_data[31:6] == 26'h0)
      else $error("reserved switch register bits read non-zero");

endmodule : lp_dac_switch_and_ref_regs

// [common/lp_dac_regs_pkg.sv]
// Shared constants and carriers for the low power DAC switch and reference register bank.
// Assumes a 32-bit AHB-Lite fabric and word-aligned register addresses.
package lp_dac_regs_pkg;

   // ***************************************************************
   // Register byte addresses
   // ***************************************************************
   localparam logic [31:0] REF_CTRL_ADDR = 32'h0000_2050;   // lp_reference_power_control
   localparam logic [31:0] DAC_CODE_ADDR = 32'h0000_2120;   // lp_dac_output_code
   localparam logic [31:0] SW_CTRL_ADDR  = 32'h0000_2124;   // lp_dac_switch_control
   localparam logic [31:0] DAC_CFG_ADDR  = 32'h0000_2128;   // dac_configuration
   localparam logic [31:0] CM_MUX_ADDR   = 32'h0000_235C;   // common_mode_switch_select

   // ***************************************************************
   // Field positions and widths
   // ***************************************************************
   localparam int SW_VEC_W            = 5;    // Five output switches
   localparam int SW_OVERRIDE_BIT     = 5;    // switch_override
   localparam int SW_BIAS_AMP_BIT     = 4;    // bias_to_amp_input_close
   localparam int SW_BIAS_FILT_BIT    = 3;    // bias_to_filter_pin_close
   localparam int SW_ZERO_LP_BIT      = 2;    // zero_to_lp_tia_input_close
   localparam int SW_ZERO_FILT_BIT    = 1;    // zero_to_filter_pin_close
   localparam int SW_ZERO_HS_BIT      = 0;    // zero_to_hs_tia_input_close
   localparam int CODE6_LSB           = 12;   // dac_code_6bit
   localparam int CODE6_W             = 6;
   localparam int CODE12_LSB          = 0;    // dac_code_12bit
   localparam int CODE12_W            = 12;
   localparam int REF_BUF_PD_BIT      = 1;    // ref_buffer_power_down
   localparam int BANDGAP_PD_BIT      = 0;    // bandgap_power_down
   localparam int CM_EN_BIT           = 3;    // common_mode_switch_enable
   localparam int CFG_MODE_BIT        = 5;    // diagnostic_switch_mode
   localparam int CFG_PD_BIT          = 1;    // dac_power_down
   localparam int CFG_WREN_BIT        = 0;    // dac_write_enable

   // ***************************************************************
   // Writable masks and reset values
   // ***************************************************************
   localparam logic [31:0] SW_CTRL_MASK  = 32'h0000_003F;
   localparam logic [31:0] DAC_CODE_MASK = 32'h0003_FFFF;
   localparam logic [31:0] REF_CTRL_MASK = 32'h0000_0003;
   localparam logic [31:0] CM_MUX_MASK   = 32'h0000_000F;
   localparam logic [31:0] DAC_CFG_MASK  = 32'h0000_007F;
   localparam logic [31:0] SW_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] DAC_CODE_RST  = 32'h0000_0000;
   localparam logic [31:0] REF_CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] CM_MUX_RST    = 32'h0000_0000;
   localparam logic [31:0] DAC_CFG_RST   = 32'h0000_0002;

   // Switch patterns used while the override is clear
   localparam logic [4:0]  SW_NORMAL_SET = 5'h0A;           // Both DACs to their filter pins
   localparam logic [4:0]  SW_DIAG_SET   = 5'h14;           // Both DACs straight to amp inputs

   // ***************************************************************
   // Carriers and states
   // ***************************************************************
   typedef struct packed {
      logic        en;
      logic [31:0] addr;
      logic [31:0] data;
   } reg_wr_t;

   typedef struct packed {
      logic        en;
      logic [31:0] addr;
   } reg_rd_t;

   typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_RD_WAIT, ST_RD_DONE} ahb_state_t;

endpackage : lp_dac_regs_pkg

// [src/ahb_reg_slave.sv]
// AHB-Lite slave front end: turns bus transfers into register write and read requests.
// Assumes one master, single word transfers; answers are always OKAY.
`timescale 1ns/1ps
module ahb_reg_slave
   import lp_dac_regs_pkg::*;
(
   input  wire logic                         mclk,       // System clock
   input  wire logic                         reset_n,    // Async reset, active low
   input  wire logic                         hsel,       // Slave select
   input  wire logic [31:0]                  haddr,      // Byte address
   input  wire logic [1:0]                   htrans,     // Transfer type
   input  wire logic                         hwrite,     // Write when high
   input  wire logic [31:0]                  hwdata,     // Write data
   input  wire logic                         hready,     // Bus ready
   output logic [31:0]                       hrdata,     // Read data
   output logic                              hreadyout,  // Slave ready
   output logic                              hresp,      // Always OKAY
   output lp_dac_regs_pkg::reg_wr_t          wr_req,     // Write request
   output lp_dac_regs_pkg::reg_rd_t          rd_req,     // Read request
   input  wire logic [31:0]                  rd_data     // Read mux result
);
   import lp_dac_regs_pkg::*;

   ahb_state_t  state_ff;
   logic [31:0] addr_ff;
   logic [31:0] hrdata_ff;
   logic        hreadyout_ff;
   logic        hresp_ff;
   logic        accept;

   // ***************************************************************
   // Address phase capture
   // ***************************************************************
   assign accept = hsel && htrans[1] && hready;

   // Reads take one wait state so a write just ahead of them is already stored
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff     <= ST_IDLE;
         addr_ff      <= 32'h0000_0000;
         hreadyout_ff <= 1'b1;
      end
      else if (state_ff == ST_RD_WAIT)
      begin
         state_ff     <= ST_RD_DONE;
         hreadyout_ff <= 1'b1;
      end
      else if (accept)
      begin
         addr_ff      <= haddr;
         state_ff     <= hwrite ? ST_WRITE : ST_RD_WAIT;
         hreadyout_ff <= hwrite;
      end
      else
      begin
         state_ff     <= ST_IDLE;
         hreadyout_ff <= 1'b1;
      end
   end

   // Read data is loaded during the wait state
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         hrdata_ff <= 32'h0000_0000;
      else if (state_ff == ST_RD_WAIT)
         hrdata_ff <= rd_data;
   end

   // Error response is never used
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         hresp_ff <= 1'b0;
      else
         hresp_ff <= 1'b0;
   end

   // ***************************************************************
   // Requests toward the register bank
   // ***************************************************************
   assign wr_req.en   = (state_ff == ST_WRITE);
   assign wr_req.addr = addr_ff;
   assign wr_req.data = hwdata;
   assign rd_req.en   = (state_ff == ST_RD_WAIT);
   assign rd_req.addr = addr_ff;
   assign hrdata      = hrdata_ff;
   assign hreadyout   = hreadyout_ff;
   assign hresp       = hresp_ff;

   sequence seq_read_taken;
      accept && !hwrite && state_ff != ST_RD_WAIT;
   endsequence

   sequence seq_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence

   chk_read_wait_state : assert property (@(posedge mclk) disable iff (!reset_n)
      seq_read_taken |=> seq_one_wait)
      else $error("read did not answer after exactly one wait state");

endmodule : ahb_reg_slave

// [test/tb_top.sv]
// Self-checking bench for the low power DAC switch and reference register bank.
// Assumes the bank answers AHB-Lite reads with one wait state and writes with none.
`timescale 1ns/1ps
module tb_top;
   import lp_dac_regs_pkg::*;
   // ***************************************************************
   // Stimulus signals and bookkeeping
   // ***************************************************************
   localparam logic [31:0] UNMAPPED_ADDR = 32'h0000_2130;
   logic        mclk = 1'b0, reset_n = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, c, s, d, r, m, dat_m;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, dac_power_down, ref_buffer_power_down, bandgap_power_down;
   logic        bias_to_amp_input_close, bias_to_filter_pin_close, zero_to_lp_tia_input_close;
   logic        zero_to_filter_pin_close, zero_to_hs_tia_input_close, common_mode_switch_enable;
   logic [5:0]  dac_code_6bit;
   logic [11:0] dac_code_12bit;
   logic [4:0]  sw_vec;
   int          n_errors = 0, compares = 0, seed = 38108;
   logic [31:0] addrs [4] = '{REF_CTRL_ADDR, DAC_CODE_ADDR, SW_CTRL_ADDR, CM_MUX_ADDR};

   // Clock and collected switch vector
   always #12.5 mclk = ~mclk;
   assign sw_vec = {bias_to_amp_input_close, bias_to_filter_pin_close,
                    zero_to_lp_tia_input_close, zero_to_filter_pin_close,
                    zero_to_hs_tia_input_close};

   lp_dac_switch_and_ref_regs dut_u (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .bias_to_amp_input_close,
      .bias_to_filter_pin_close, .zero_to_lp_tia_input_close, .zero_to_filter_pin_close,
      .zero_to_hs_tia_input_close, .dac_code_6bit, .dac_code_12bit, .dac_power_down,
      .ref_buffer_power_down, .bandgap_power_down, .common_mode_switch_enable);

   // Power-down wins, then the override, then the mode pattern
   function automatic logic [4:0] exp_sw(input logic [31:0] cfg, input logic [31:0] sw);
      if (cfg[1])
         return 5'h00;
      if (sw[5])
         return sw[4:0];
      return cfg[5] ? 5'h14 : 5'h0A;
   endfunction : exp_sw

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Ready is looked at in the settled half before the edge, so no race with its update
   task automatic wait_rdy();
      @(negedge mclk);
      while (hreadyout !== 1'b1)
         @(negedge mclk);
      rd = hrdata;
      @(posedge mclk);
   endtask : wait_rdy

   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
   endtask : bus

   // Every register and output must hold its reset value after any reset release
   task automatic reset_checks();
      foreach (addrs[i])
      begin
         bus(1'b0, addrs[i], 32'h0);
         check(rd, 32'h0);
      end
      bus(1'b0, DAC_CFG_ADDR, 32'h0);
      check(rd, DAC_CFG_RST);
      @(negedge mclk);
      check({27'h0, sw_vec}, 32'h0);
      check({31'h0, dac_power_down}, 32'h1);
      check({14'h0, dac_code_6bit, dac_code_12bit}, 32'h0);
      check({29'h0, ref_buffer_power_down, bandgap_power_down, common_mode_switch_enable},
            32'h0);
      @(posedge mclk);
   endtask : reset_checks

   task automatic conclude();
      $display("counts: %0d compares, %0d mismatches", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // Watchdog sized well above the expected run length
   initial
   begin
      #(25 * 40000);
      n_errors++;
      conclude();
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      reset_checks();
      $display("reset test done");
      // First passes are hand-picked: normal, diagnostic, full override with all-ones data
      for (int i = 0; i < 40; i++)
      begin
         c = $random(seed) & 32'h7F;
         s = $random(seed);
         d = $random(seed);
         r = $random(seed);
         m = $random(seed);
         if (i < 3)
         begin
            c = (i == 1) ? 32'h21 : 32'h01;
            s = (i == 2) ? 32'hFFFF_FFFF : 32'h0;
            d = 32'hFFFF_FFFF;
         end
         bus(1'b1, DAC_CFG_ADDR, c);
         bus(1'b1, SW_CTRL_ADDR, s);
         bus(1'b1, DAC_CODE_ADDR, d);
         bus(1'b1, REF_CTRL_ADDR, r);
         bus(1'b1, CM_MUX_ADDR, m);
         bus(1'b1, UNMAPPED_ADDR, d);
         dat_m = c[0] ? (d & 32'h3_FFFF) : 32'h0;
         bus(1'b0, REF_CTRL_ADDR, 32'h0);
         check(rd, r & 32'h3);
         bus(1'b0, DAC_CODE_ADDR, 32'h0);
         check(rd, dat_m);
         bus(1'b0, SW_CTRL_ADDR, 32'h0);
         check(rd, s & 32'h3F);
         bus(1'b0, CM_MUX_ADDR, 32'h0);
         check(rd, m & 32'hF);
         bus(1'b0, DAC_CFG_ADDR, 32'h0);
         check(rd, c & 32'h7F);
         bus(1'b0, UNMAPPED_ADDR, 32'h0);
         check(rd, 32'h0);
         check({31'h0, hresp}, 32'h0);
         @(negedge mclk);
         check({27'h0, sw_vec}, {27'h0, exp_sw(c, s)});
         check({14'h0, dac_code_6bit, dac_code_12bit}, dat_m);
         check({29'h0, dac_power_down, ref_buffer_power_down, bandgap_power_down},
               {29'h0, c[1], r[1:0]});
         check({31'h0, common_mode_switch_enable}, {31'h0, m[3]});
         @(posedge mclk);
         $display("register test %0d done", i);
      end
      // Mid-run reset: the values written above must fall back to their reset values
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      reset_checks();
      $display("mid-run reset test done");
      conclude();
   end
endmodule : tb_top
